// *** fgc_cfg.svh ***
`ifndef FGC_CFG_SVH
`define FGC_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define FGC_OFF_ENC_LIMIT_DIV   8'h00
`define FGC_OFF_TIMING_GEN      8'h04
`define FGC_OFF_VWIN_POL        8'h08
`define FGC_OFF_LINE_DIVISOR    8'h0c
`define FGC_OFF_VIDEO_DIAG      8'h10
`define FGC_OFF_COLOUR_DEC      8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FGC_DIV_FREE_BIT        28
`define FGC_DIV_REFSEL_LSB      29
`define FGC_DIV_REFSEL_MSB      31
`define FGC_GEN_PERIOD_MSB      27
`define FGC_GEN_SINGLE_BIT      30
`define FGC_GEN_TRIGSRC_BIT     31
`define FGC_ALC_MSB             16
`define FGC_FWREV_LSB           17
`define FGC_FWREV_MSB           29
`define FGC_GEN_POL_BIT         30
`define FGC_GEN_PRESCALE_BIT    31
`define FGC_REMAIN_MSB          16
`define FGC_DIVF_LSB            17
`define FGC_DIVF_MSB            19
`define FGC_DIAG_SHF_LSB        8
`define FGC_DIAG_MEM_LSB        16
`define FGC_MASK_LSB            24
`define FGC_MASK_MSB            25
`define FGC_SHSEL_BIT           26
`define FGC_SHAMT_LSB           27
`define FGC_SHAMT_MSB           30
`define FGC_SHLEFT_BIT          31
`define FGC_GAIN_G_LSB          8
`define FGC_GAIN_B_LSB          16
`define FGC_DOUT_LSB            24
`define FGC_DOUT_MSB            26
`define FGC_DEPTH_LSB           28
`define FGC_DEPTH_MSB           29
`define FGC_PHASE_LSB           30
`define FGC_PHASE_MSB           31

// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define FGC_RST_WORD            32'h0000_0000
`define FGC_RST_GAIN            8'h40
`define FGC_PRESCALE_DIV        128
`define FGC_GAIN_SHIFT          6
`define FGC_PIX_MAX             8'hff

`endif

// *** fgc_pkg.sv ***
package fgc_pkg;

  typedef enum logic [1:0] {FGC_MASK_ALL, FGC_MASK_RED, FGC_MASK_GREEN,
                            FGC_MASK_BLUE} fgc_mask_t;

  typedef enum logic [2:0] {FGC_OUT_RGB, FGC_OUT_RAW, FGC_OUT_INTENS, FGC_OUT_RED,
                            FGC_OUT_GREEN, FGC_OUT_BLUE, FGC_OUT_RSV6,
                            FGC_OUT_RSV7} fgc_dec_out_t;

  typedef enum logic [1:0] {FGC_DEPTH_8, FGC_DEPTH_12, FGC_DEPTH_10,
                            FGC_DEPTH_RSV} fgc_depth_t;

  typedef enum logic [1:0] {FGC_PH_BG, FGC_PH_GB, FGC_PH_RG, FGC_PH_GR} fgc_phase_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } fgc_rgb_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } fgc_wb_req_t;

  typedef struct packed {
    fgc_depth_t pixel_depth;
    fgc_phase_t start_phase;
  } fgc_bayer_cfg_t;

endpackage

// *** fgc_line_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fgc_cfg.svh"

module fgc_line_gen
  import fgc_pkg::*;
#(
  parameter int PERIOD_W = 28
)
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                gen_tick,
  input  wire logic                start_pulse,
  input  wire logic [PERIOD_W-1:0] period,
  input  wire logic                single_shot,
  input  wire logic                prescale,
  input  wire logic                invert,
  output var  logic                gen_out
);

  if (PERIOD_W < 2 || PERIOD_W > 31)
  begin : g_bad_width
    $error("fgc_line_gen: PERIOD_W out of range");
  end

  localparam logic [6:0] PRE_LAST = 7'(`FGC_PRESCALE_DIV - 1);

  logic [6:0]          pre_cnt_reg;
  logic [PERIOD_W-1:0] cnt_reg;
  logic                run_reg;
  logic                unit_tick;
  logic                last_unit;
  logic                active;

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pre_cnt_reg <= '0;
    else if (gen_tick)
      pre_cnt_reg <= pre_cnt_reg + 7'd1;
  end

  assign unit_tick = gen_tick && (!prescale || pre_cnt_reg == PRE_LAST);
  assign last_unit = unit_tick && (cnt_reg == period - 1'b1);

  // ---------------------------------------------------------------
  // Period counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      run_reg <= 1'b0;
    else if (period == '0)
      run_reg <= 1'b0;
    else if (!single_shot)
      run_reg <= 1'b1;
    else if (!run_reg && start_pulse)
      run_reg <= 1'b1;
    else if (last_unit)
      run_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !run_reg)
      cnt_reg <= '0;
    else if (last_unit)
      cnt_reg <= '0;
    else if (unit_tick)
      cnt_reg <= cnt_reg + 1'b1;
  end

  // High for the first half of each period; a period of one stays low
  assign active = run_reg && (cnt_reg < (period >> 1));

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      gen_out <= 1'b0;
    else
      gen_out <= active ^ invert;
  end

  count_wrap_a : assert property (@(posedge ref_clk) disable iff (rst)
    run_reg && last_unit && !single_shot |=> cnt_reg == '0)
    else $error("period counter did not wrap");

  single_stop_a : assert property (@(posedge ref_clk) disable iff (rst)
    single_shot && run_reg && last_unit && period != '0 |=> !run_reg)
    else $error("single shot did not stop");

  polarity_a : assert property (@(posedge ref_clk) disable iff (rst)
    !run_reg && !$changed(invert) |=> gen_out == $past(invert))
    else $error("idle level ignores polarity");

  prescale_a : assert property (@(posedge ref_clk) disable iff (rst)
    prescale && gen_tick && pre_cnt_reg != PRE_LAST |-> !unit_tick)
    else $error("prescaler let a tick through");

endmodule

`default_nettype wire

// *** fgc_regs.sv ***
// Summary of operation
// - Free-run bit 0 locks divider, 1 frees it
// - 28-bit period counts timing generator clocks
// - Single-shot bit: one period per trigger
// - Trigger source: trigger input or encoder
// - Polarity bit 1 makes output active low
// - Prescale bit divides generator clock by 128
// - Active line count sets vertical window
// - Lines remaining shows lines left in frame
// - 3-bit factor N drives encoder divider
// - Three read-only live diagnostic bytes
// - Colour mask passes all or one channel
// - Shift select picks acquisition or display code
// - 4-bit display shift amount
// - Direction bit: 0 right, 1 left
// - Gain multiply, divide by 64, saturate
// - Decoder output select, two codes reserved
// - Decoder control fields are soft
// - Pixel depth select 8, 12, 10 bits
// - Start phase selects first colour pair
`timescale 1ns/10ps
`default_nettype none
`include "fgc_cfg.svh"

module fgc_regs
  import fgc_pkg::*;
#(
  parameter int          PERIOD_W   = 28,
  parameter int          LINES_W    = 17,
  parameter int          ENC_W      = 24,
  parameter logic [12:0] FW_REVISION = 13'h0000 // Arbitrary value
)
(
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire fgc_wb_req_t    wb_req,
  output var  logic [31:0]    wb_dat_o,
  output var  logic           wb_ack_o,
  input  wire logic           gen_tick,
  input  wire logic           trig_pulse,
  input  wire logic           enc_pulse,
  output var  logic           gen_out,
  output var  logic           div_out,
  input  wire logic           frame_start,
  input  wire logic           line_valid,
  input  wire logic [7:0]     diag_input_tap_byte,
  input  wire logic [7:0]     diag_memory_write_byte,
  input  wire logic [15:0]    shift_in,
  input  wire logic [3:0]     acq_shift_code,
  output var  logic [15:0]    shift_out,
  input  wire logic           pix_valid,
  input  wire fgc_rgb_t       pix_in,
  input  wire logic [7:0]     pix_raw,
  output var  logic           pix_valid_out,
  output var  fgc_rgb_t       pix_out,
  output var  fgc_bayer_cfg_t bayer_cfg
);

  if (PERIOD_W != `FGC_GEN_PERIOD_MSB + 1 || LINES_W != `FGC_ALC_MSB + 1 ||
      ENC_W < 4 || ENC_W > 30)
  begin : g_bad_param
    $error("fgc_regs: unsupported parameter value");
  end

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic        req;
  logic        wr_fire;
  logic [31:0] wmask;
  logic [31:0] rd_next;

  assign req     = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign wr_fire = req && wb_req.we;

  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    assign wmask[8*i +: 8] = {8{wb_req.sel[i]}};
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wb_dat_o <= `FGC_RST_WORD;
    else if (req && !wb_req.we)
      wb_dat_o <= rd_next;
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  logic [31:0] enc_ctrl_reg;
  logic [31:0] gen_ctrl_reg;
  logic [31:0] vwin_reg;
  logic [31:0] diag_ctrl_reg;
  logic [31:0] dec_ctrl_reg;
  logic [2:0]  divf_reg;
  logic [31:0] w;

  assign w = wb_req.dat;

  // Merge at bit 0 with the byte mask shifted down alongside the data, so byte lanes still apply after the shift down
  logic [31:0] divf_merged;

  assign divf_merged = merge({29'd0, divf_reg}, w >> `FGC_DIVF_LSB, wmask >> `FGC_DIVF_LSB);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      enc_ctrl_reg  <= `FGC_RST_WORD;
      gen_ctrl_reg  <= `FGC_RST_WORD;
      vwin_reg      <= `FGC_RST_WORD;
      diag_ctrl_reg <= `FGC_RST_WORD;
      dec_ctrl_reg  <= {8'(`FGC_RST_WORD >> `FGC_DOUT_LSB), `FGC_RST_GAIN, `FGC_RST_GAIN,
                        `FGC_RST_GAIN};
      divf_reg      <= '0;
    end
    else if (wr_fire)
    begin
      unique case (wb_req.adr)
        `FGC_OFF_ENC_LIMIT_DIV:
          enc_ctrl_reg <= merge(enc_ctrl_reg, w, wmask);
        `FGC_OFF_TIMING_GEN:
          gen_ctrl_reg <= merge(gen_ctrl_reg, w, wmask);
        `FGC_OFF_VWIN_POL:
          vwin_reg <= merge(vwin_reg, w, wmask);
        `FGC_OFF_LINE_DIVISOR:
          divf_reg <= divf_merged[`FGC_DIVF_MSB-`FGC_DIVF_LSB:0];
        `FGC_OFF_VIDEO_DIAG:
          diag_ctrl_reg <= merge(diag_ctrl_reg, w, wmask);
        `FGC_OFF_COLOUR_DEC:
          dec_ctrl_reg <= merge(dec_ctrl_reg, w, wmask);
        default:
        begin
        end
      endcase
    end
  end

  // Field views
  logic                divider_free_run;
  logic [2:0]          divider_ref_clock_select;
  logic [PERIOD_W-1:0] generator_period;
  logic                generator_single_shot;
  logic                generator_trigger_source;
  logic [LINES_W-1:0]  active_line_count;
  logic                generator_output_polarity;
  logic                generator_clock_prescale;
  fgc_mask_t           colour_mask;
  logic                shift_display_select;
  logic [3:0]          display_shift;
  logic                display_shift_left;
  logic [7:0]          gain_red;
  logic [7:0]          gain_green;
  logic [7:0]          gain_blue;
  fgc_dec_out_t        decoder_out_select;

  assign divider_free_run          = enc_ctrl_reg[`FGC_DIV_FREE_BIT];
  // Only the zero code is meaningful; the field is stored for read-back
  assign divider_ref_clock_select  = enc_ctrl_reg[`FGC_DIV_REFSEL_MSB:`FGC_DIV_REFSEL_LSB];
  assign generator_period          = gen_ctrl_reg[`FGC_GEN_PERIOD_MSB:0];
  assign generator_single_shot     = gen_ctrl_reg[`FGC_GEN_SINGLE_BIT];
  assign generator_trigger_source  = gen_ctrl_reg[`FGC_GEN_TRIGSRC_BIT];
  assign active_line_count         = vwin_reg[`FGC_ALC_MSB:0];
  assign generator_output_polarity = vwin_reg[`FGC_GEN_POL_BIT];
  assign generator_clock_prescale  = vwin_reg[`FGC_GEN_PRESCALE_BIT];
  assign colour_mask               = fgc_mask_t'(diag_ctrl_reg[`FGC_MASK_MSB:`FGC_MASK_LSB]);
  assign shift_display_select      = diag_ctrl_reg[`FGC_SHSEL_BIT];
  assign display_shift             = diag_ctrl_reg[`FGC_SHAMT_MSB:`FGC_SHAMT_LSB];
  assign display_shift_left        = diag_ctrl_reg[`FGC_SHLEFT_BIT];
  assign gain_red                  = dec_ctrl_reg[7:0];
  assign gain_green                = dec_ctrl_reg[`FGC_GAIN_G_LSB +: 8];
  assign gain_blue                 = dec_ctrl_reg[`FGC_GAIN_B_LSB +: 8];
  assign decoder_out_select        = fgc_dec_out_t'(dec_ctrl_reg[`FGC_DOUT_MSB:`FGC_DOUT_LSB]);

  // ---------------------------------------------------------------
  // Lines remaining
  // ---------------------------------------------------------------
  logic [LINES_W-1:0] lines_remaining_reg;
  logic [31:0]        remain_merged;

  assign remain_merged = merge({15'd0, lines_remaining_reg}, w, wmask);

  // A software write wins over a line count in the same cycle, so a
  // reload is never half-applied
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      lines_remaining_reg <= '0;
    else if (wr_fire && wb_req.adr == `FGC_OFF_LINE_DIVISOR)
      lines_remaining_reg <= remain_merged[`FGC_REMAIN_MSB:0];
    else if (frame_start)
      lines_remaining_reg <= active_line_count;
    else if (line_valid && lines_remaining_reg != '0)
      lines_remaining_reg <= lines_remaining_reg - 1'b1;
  end

  lines_count_a : assert property (@(posedge ref_clk) disable iff (rst)
    line_valid && !frame_start && !wr_fire && lines_remaining_reg != '0
    |=> lines_remaining_reg == $past(lines_remaining_reg) - 1'b1)
    else $error("lines remaining did not count down");

  // ---------------------------------------------------------------
  // Timing generator
  // ---------------------------------------------------------------
  logic gen_start;

  assign gen_start = generator_trigger_source ? enc_pulse : trig_pulse;

  fgc_line_gen #(
    .PERIOD_W (PERIOD_W)
  ) u_line_gen (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .gen_tick    (gen_tick),
    .start_pulse (gen_start),
    .period      (generator_period),
    .single_shot (generator_single_shot),
    .prescale    (generator_clock_prescale),
    .invert      (generator_output_polarity),
    .gen_out     (gen_out)
  );

  // ---------------------------------------------------------------
  // Encoder divider
  // ---------------------------------------------------------------
  // Locked mode restarts on the encoder; free-run replays the last
  // measured group interval and ignores encoder phase
  logic [2:0]       grp_cnt_reg;
  logic [ENC_W-1:0] meas_reg;
  logic [ENC_W-1:0] interval_reg;
  logic [ENC_W-1:0] free_cnt_reg;
  logic             grp_end;
  logic             free_end;

  assign grp_end  = enc_pulse && grp_cnt_reg == divf_reg;
  assign free_end = free_cnt_reg >= interval_reg && interval_reg != '0;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      grp_cnt_reg <= '0;
    else if (grp_end)
      grp_cnt_reg <= '0;
    else if (enc_pulse)
      grp_cnt_reg <= grp_cnt_reg + 3'd1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meas_reg     <= '0;
      interval_reg <= '0;
    end
    else if (grp_end)
    begin
      meas_reg     <= '0;
      interval_reg <= meas_reg;
    end
    else if (meas_reg != '1)
      meas_reg <= meas_reg + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || !divider_free_run || free_end)
      free_cnt_reg <= '0;
    else
      free_cnt_reg <= free_cnt_reg + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      div_out <= 1'b0;
    else
      div_out <= divider_free_run ? free_end : grp_end;
  end

  div_locked_a : assert property (@(posedge ref_clk) disable iff (rst)
    !divider_free_run && !$past(divider_free_run) |=> div_out == $past(grp_end))
    else $error("locked divider lost input phase");

  // ---------------------------------------------------------------
  // Barrel shifter and diagnostics
  // ---------------------------------------------------------------
  logic [15:0] shift_next;
  logic [7:0]  diag_tap_reg;
  logic [7:0]  diag_mem_reg;

  always_comb
  begin
    if (!shift_display_select)
      shift_next = shift_in >> acq_shift_code;
    else if (display_shift_left)
      shift_next = shift_in << display_shift;
    else
      shift_next = shift_in >> display_shift;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      shift_out    <= '0;
      diag_tap_reg <= '0;
      diag_mem_reg <= '0;
    end
    else
    begin
      shift_out    <= shift_next;
      diag_tap_reg <= diag_input_tap_byte;
      diag_mem_reg <= diag_memory_write_byte;
    end
  end

  shift_sel_a : assert property (@(posedge ref_clk) disable iff (rst)
    !shift_display_select |=> shift_out == $past(shift_in) >> $past(acq_shift_code))
    else $error("acquisition shift code not applied");

  // ---------------------------------------------------------------
  // Colour path: gain, select, mask
  // ---------------------------------------------------------------
  function automatic logic [7:0] apply_gain(input logic [7:0] pix, input logic [7:0] g);
    logic [15:0] prod;
    prod = (16'(pix) * 16'(g)) >> `FGC_GAIN_SHIFT;
    apply_gain = (prod > 16'(`FGC_PIX_MAX)) ? `FGC_PIX_MAX : prod[7:0];
  endfunction

  fgc_rgb_t   gained;
  fgc_rgb_t   sel_pix;
  fgc_rgb_t   mask_pix;
  logic [9:0] intens;

  assign gained.red   = apply_gain(pix_in.red, gain_red);
  assign gained.green = apply_gain(pix_in.green, gain_green);
  assign gained.blue  = apply_gain(pix_in.blue, gain_blue);
  assign intens       = 10'(gained.red) + 10'(gained.blue) + {1'b0, gained.green, 1'b0};

  always_comb
  begin
    case (decoder_out_select)
      FGC_OUT_RAW:    sel_pix = {3{pix_raw}};
      FGC_OUT_INTENS: sel_pix = {3{intens[9:2]}};
      FGC_OUT_RED:    sel_pix = {3{gained.red}};
      FGC_OUT_GREEN:  sel_pix = {3{gained.green}};
      FGC_OUT_BLUE:   sel_pix = {3{gained.blue}};
      default:        sel_pix = gained;
    endcase
    mask_pix = sel_pix;
    unique case (colour_mask)
      FGC_MASK_ALL:   mask_pix = sel_pix;
      FGC_MASK_RED:   mask_pix = '{red: sel_pix.red, green: 8'h00, blue: 8'h00};
      FGC_MASK_GREEN: mask_pix = '{red: 8'h00, green: sel_pix.green, blue: 8'h00};
      FGC_MASK_BLUE:  mask_pix = '{red: 8'h00, green: 8'h00, blue: sel_pix.blue};
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pix_out       <= '0;
      pix_valid_out <= 1'b0;
    end
    else
    begin
      pix_out       <= mask_pix;
      pix_valid_out <= pix_valid;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bayer_cfg <= '0;
    else
      bayer_cfg <= '{pixel_depth: fgc_depth_t'(dec_ctrl_reg[`FGC_DEPTH_MSB:`FGC_DEPTH_LSB]),
                     start_phase: fgc_phase_t'(dec_ctrl_reg[`FGC_PHASE_MSB:`FGC_PHASE_LSB])};
  end

  mask_red_a : assert property (@(posedge ref_clk) disable iff (rst)
    colour_mask == FGC_MASK_RED |=> pix_out.green == 8'h00 && pix_out.blue == 8'h00)
    else $error("red mask leaked other channels");

  gain_sat_a : assert property (@(posedge ref_clk) disable iff (rst)
    decoder_out_select == FGC_OUT_RGB && colour_mask == FGC_MASK_ALL &&
    (16'(pix_in.red) * 16'(gain_red)) >> `FGC_GAIN_SHIFT > 16'(`FGC_PIX_MAX)
    |=> pix_out.red == `FGC_PIX_MAX)
    else $error("gain did not saturate");

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_next = '0;
    unique case (wb_req.adr)
      `FGC_OFF_ENC_LIMIT_DIV:
        rd_next = enc_ctrl_reg;
      `FGC_OFF_TIMING_GEN:
        rd_next = gen_ctrl_reg & ~(32'h3 << (`FGC_GEN_PERIOD_MSB + 1));
      `FGC_OFF_VWIN_POL:
        rd_next = {vwin_reg[31:30], FW_REVISION, vwin_reg[`FGC_ALC_MSB:0]};
      `FGC_OFF_LINE_DIVISOR:
        rd_next = {12'd0, divf_reg, lines_remaining_reg};
      `FGC_OFF_VIDEO_DIAG:
        rd_next = {diag_ctrl_reg[31:24], diag_mem_reg, shift_out[7:0], diag_tap_reg};
      `FGC_OFF_COLOUR_DEC:
        rd_next = {dec_ctrl_reg[31:28], 1'b0, dec_ctrl_reg[26:0]};
      default:
        rd_next = '0;
    endcase
  end

  bus_ack_a : assert property (@(posedge ref_clk) disable iff (rst)
    wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

  reserved_rd_a : assert property (@(posedge ref_clk) disable iff (rst)
    req && !wb_req.we && wb_req.adr == `FGC_OFF_LINE_DIVISOR |=> wb_dat_o[31:20] == 12'd0)
    else $error("reserved bits read non-zero");

endmodule

`default_nettype wire

// *** fgc_regs_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module fgc_regs_test import fgc_pkg::*;;
  logic           ref_clk = 1'b0;
  logic           rst = 1'b1;
  fgc_wb_req_t    wb_req;
  logic [31:0]    wb_dat_o, q, lf, d;
  logic           wb_ack_o, gen_out, div_out, frame_start, line_valid, pix_valid, pix_valid_out;
  logic [7:0]     tap, mem, raw;
  logic [3:0]     acq;
  logic           trig, enc;
  logic [15:0]    sh_in, shift_out;
  fgc_rgb_t       pix_in, pix_out;
  fgc_bayer_cfg_t bayer_cfg;
  int             bad_count, checks, cyc, i, n;
  logic [31:0]    mdl [7];
  // Writable bits per offset; the diag register keeps only its top byte
  const logic [31:0] msk [7] = '{'1, 32'hcfffffff, 32'hc001ffff, 32'h000fffff,
                                 32'hff000000, 32'hf7ffffff, 0};

  always #5 ref_clk = ~ref_clk;

  fgc_regs u_dut (.ref_clk(ref_clk), .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .gen_tick(1'b1), .trig_pulse(trig), .enc_pulse(enc),
    .gen_out(gen_out), .div_out(div_out), .frame_start(frame_start), .line_valid(line_valid),
    .diag_input_tap_byte(tap), .diag_memory_write_byte(mem), .shift_in(sh_in),
    .acq_shift_code(acq), .shift_out(shift_out), .pix_valid(pix_valid), .pix_in(pix_in),
    .pix_raw(raw), .pix_valid_out(pix_valid_out), .pix_out(pix_out), .bayer_cfg(bayer_cfg));

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [7:0] gn(input int p, input int g);
    return (p * g / 64 > 255) ? 8'hff : 8'(p * g / 64);
  endfunction

  function automatic logic [23:0] px(input logic [31:0] c, input logic [1:0] m,
                                     input logic [23:0] p, input logic [7:0] rw);
    logic [7:0] r, g, b, y;
    r = gn(p[23:16], c[7:0]);
    g = gn(p[15:8], c[15:8]);
    b = gn(p[7:0], c[23:16]);
    y = 8'((r + 2 * g + b) / 4);
    case (c[26:24])
      3'd1: {r, g, b} = {3{rw}};
      3'd2: {r, g, b} = {3{y}};
      3'd3: {g, b} = {r, r};
      3'd4: {r, b} = {g, g};
      3'd5: {r, g} = {b, b};
      default: ;
    endcase
    if (m != 2'd0 && m != 2'd1) r = 8'h00;
    if (m != 2'd0 && m != 2'd2) g = 8'h00;
    if (m != 2'd0 && m != 2'd3) b = 8'h00;
    return {r, g, b};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Classic bus cycle: hold until ack is sampled, then one idle cycle
  // ---------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dw);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hf, dw};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1)
      @(posedge ref_clk);
    q = wb_dat_o;
    wb_req <= '0;
    @(posedge ref_clk);
    if (we && a < 8'h18) mdl[a/4] = dw & msk[a/4] | mdl[a/4] & ~msk[a/4];
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
    // Reads come before the shift test, so the shifter byte is still zero
    chk(q, mdl[a/4] | ((a == 8'h10) ? {8'h0, mem, 8'h0, tap} : 0), "register");
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    {wb_req, frame_start, line_valid, pix_in, raw, acq, trig, enc} = '0;
    {pix_valid, tap, mem, sh_in, lf} = {1'b1, 8'h5a, 8'ha5, 16'h0, 32'hdbff6299};
    mdl = '{0, 0, 0, 0, 0, 32'h00404040, 0};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 7; i++) rd(8'(i * 4));
    for (i = 0; i < 7; i++)
    begin
      lf = nx(lf);
      {tap, mem} <= lf[23:8];
      wb(1'b1, 8'(i * 4), (i == 0) ? lf & 32'h1fffffff : lf);
      rd(8'(i * 4));
    end
    $display("register test done");
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h0c, 32'h00020000);
    n = 0;
    repeat (4)
    begin
      enc <= 1'b1;
      @(posedge ref_clk);
      enc <= 1'b0;
      repeat (2) @(posedge ref_clk) n += (div_out === 1'b1);
    end
    chk(n, 2, "divider pulses");
    $display("divider test done");
    wb(1'b1, 8'h08, 32'h3);
    frame_start <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    @(posedge ref_clk);
    mdl[3][16:0] = 17'h3;
    rd(8'h0c);
    line_valid <= 1'b1;
    @(posedge ref_clk);
    line_valid <= 1'b0;
    @(posedge ref_clk);
    mdl[3][16:0] = 17'h2;
    rd(8'h0c);
    wb(1'b1, 8'h04, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      wb(1'b1, 8'h08, {1'b0, !i[0], 30'h3});
      repeat (3) @(posedge ref_clk);
      chk(gen_out, !i[0], "idle level");
    end
    wb(1'b1, 8'h04, 32'h4);
    repeat (4) @(posedge ref_clk);
    n = 0;
    repeat (8) @(posedge ref_clk) n += (gen_out === 1'b1);
    chk(n, 4, "active units");
    // Trigger source, then encoder source fed the wrong pulse, then the right one
    for (i = 0; i < 3; i++)
    begin
      wb(1'b1, 8'h04, {i != 0, 31'h40000004});
      repeat (6) @(posedge ref_clk);
      {trig, enc} <= {i < 2, i == 2};
      @(posedge ref_clk);
      {trig, enc} <= 2'b00;
      n = 0;
      repeat (8) @(posedge ref_clk) n += (gen_out === 1'b1);
      chk(n, (i == 1) ? 0 : 2, "single shot");
    end
    $display("generator test done");
    for (i = 0; i < 3; i++)
    begin
      wb(1'b1, 8'h10, {i[0], (i < 2) ? 31'h1c000000 : 31'h0});
      lf = nx(lf);
      {acq, sh_in} <= lf[19:0];
      d = (i == 2) ? lf[15:0] >> lf[19:16] : i ? 16'(lf[15:0] << 3) : lf[15:0] >> 3;
      repeat (2) @(posedge ref_clk);
      chk(shift_out, d, "shift");
    end
    for (i = 0; i < 11; i++)
    begin
      lf = nx(lf);
      d = {lf[31:28], 1'b0, 3'((i < 8) ? i : 0), lf[23:0]};
      wb(1'b1, 8'h10, {6'h0, 2'((i < 8) ? 0 : i - 7), 24'h0});
      wb(1'b1, 8'h14, d);
      lf = nx(lf);
      {pix_in, raw} <= lf;
      pix_valid <= lf[3];
      repeat (2) @(posedge ref_clk);
      chk(pix_valid_out, lf[3], "valid");
      chk(pix_out, px(d, 2'((i < 8) ? 0 : i - 7), lf[31:8], lf[7:0]), "pixel");
      chk(bayer_cfg, {d[29:28], d[31:30]}, "bayer");
    end
    $display("pixel test done");
    final_report();
  end
endmodule
`default_nettype wire
